/* File: hdl/ext_irq_and_vector_unit.sv */
// External pin interrupts, flags, priority and vector selection
//
// Summary of operation
// RULE1 - All resets go to vector zero
// RULE2 - External request pin vector at 0x0001
// RULE3 - Pin-change groups at 0x0002 and 0x0003
// RULE4 - Watchdog 0x0004, 16-bit timer 0x0005-0x0008
// RULE5 - 8-bit timer vectors 0x0009 to 0x000B
// RULE6 - Comparator, converter, nonvolatile, serial 0x000C-0x0010
// RULE7 - Branch only to enabled sources
// RULE8 - Pins raise requests even as outputs
// RULE9 - Low group fires on enabled pin toggle
// RULE10 - High group fires on enabled pin toggle
// RULE11 - Mask bits select contributing pins
// RULE12 - Pin changes detected without clock
// RULE13 - Sense field picks fall, rise or low
// RULE14 - Level mode requests while pin low
// RULE15 - Edges seen only with I/O clock
// RULE16 - Low level detected without clock
// RULE17 - I/O clock stopped except in idle
// RULE18 - Lost level still wakes, no interrupt
// RULE19 - Source holds level through start-up
// RULE20 - Sense codes: low, any, fall, rise
// RULE21 - Pulses over one clock are caught
// RULE22 - Flag set on edge, cleared by vector/write
// RULE23 - Needs pin enable and global enable
// RULE24 - Lowest vector address served first
`timescale 1ns/100ps
module ext_irq_and_vector_unit
    import ext_irq_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_io_clk_run,
    input wire logic i_ext_request_pin,
    input wire logic [NUM_PC-1:0] i_pin_change_inputs,
    input wire logic [7:0] i_core_control_reg,
    input wire logic i_ext_req_enable,
    input wire logic i_pc_low_enable,
    input wire logic i_pc_high_enable,
    input wire logic [7:0] i_pin_change_mask_low,
    input wire logic [7:0] i_pin_change_mask_high,
    input wire logic i_global_enable,
    input wire logic [2:0] i_flag_clear,
    input wire logic [12:0] i_other_requests,
    input wire logic i_vector_ack,
    input wire logic i_reset_event,
    input wire logic i_sleeping,
    output logic o_ext_request_flag,
    output logic o_pc_low_flag,
    output logic o_pc_high_flag,
    output logic o_irq_valid,
    output logic [VEC_W-1:0] o_vector,
    output logic [3:0] o_irq_source,
    output logic o_wake_request,
    output logic o_reset_vector_req
);
    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    logic ext_meta_r;
    logic ext_sync_r;
    logic ext_prev_r;
    logic ext_valid_r;
    logic [1:0] sense;
    logic edge_hit;
    logic level_low;
    logic ext_flag_r;
    logic pc_low_flag_r;
    logic pc_high_flag_r;
    logic pc_low_wake;
    logic pc_high_wake;
    logic pc_low_change;
    logic pc_high_change;
    logic [NUM_SRC-1:0] pending;
    logic [NUM_SRC-1:0] enabled;
    logic [NUM_SRC-1:0] active;
    logic [3:0] win_idx;
    logic win_any;
    logic [VEC_W-1:0] vector_r;
    logic [3:0] source_r;
    logic valid_r;
    logic reset_req_r;

    // Edge detection samples the pin before comparing
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ext_meta_r <= 1'b1;
            ext_sync_r <= 1'b1;
        end else begin
            ext_meta_r <= i_ext_request_pin;
            ext_sync_r <= ext_meta_r;
        end
    end

    // RULE15 previous sample only advances with I/O clock
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ext_prev_r <= 1'b1;
            ext_valid_r <= 1'b0;
        end else if (i_io_clk_run) begin
            ext_prev_r <= ext_sync_r;
            ext_valid_r <= 1'b1;
        end else begin
            // RULE17 no edges across a stopped clock
            ext_valid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Sense decode
    // ------------------------------------------------------------------
    // RULE20 sense field in bits 1..0
    assign sense = {i_core_control_reg[SENSE_HI_BIT], i_core_control_reg[SENSE_LO_BIT]};

    // RULE13 edge selection by sense field
    always_comb begin
        edge_hit = 1'b0;
        if (i_io_clk_run && ext_valid_r) begin
            case (sense)
                SENSE_ANY: begin
                    edge_hit = ext_sync_r ^ ext_prev_r;
                end
                SENSE_FALL: begin
                    edge_hit = ext_prev_r & ~ext_sync_r;
                end
                SENSE_RISE: begin
                    edge_hit = ~ext_prev_r & ext_sync_r;
                end
                default: begin
                    edge_hit = 1'b0;
                end
            endcase
        end
    end

    // RULE14 level request stands while pin low
    assign level_low = (sense == SENSE_LOW) && !ext_sync_r;

    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------
    // RULE22 set wins over clear; level mode keeps it clear
    // RULE21 any pulse held over one sample is seen
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ext_flag_r <= 1'b0;
        end else if (sense == SENSE_LOW) begin
            ext_flag_r <= 1'b0;
        end else if (edge_hit) begin
            ext_flag_r <= 1'b1;
        end else if (i_flag_clear[SRC_EXT] || (i_vector_ack && valid_r && source_r == 4'(SRC_EXT))) begin
            ext_flag_r <= 1'b0;
        end
    end

    // RULE9 low group detector
    // RULE11 mask selects contributing pins
    pin_change_group #(
        .WIDTH(PC_LOW_W)
    ) u_pc_low (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_pins(i_pin_change_inputs[PC_LOW_W-1:0]),
        .i_mask(i_pin_change_mask_low),
        .o_wake(pc_low_wake),
        .o_change(pc_low_change)
    );

    // RULE10 high group detector
    pin_change_group #(
        .WIDTH(PC_HIGH_W)
    ) u_pc_high (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_pins(i_pin_change_inputs[NUM_PC-1:PC_LOW_W]),
        .i_mask(i_pin_change_mask_high[PC_HIGH_W-1:0]),
        .o_wake(pc_high_wake),
        .o_change(pc_high_change)
    );

    // RULE8 pin state is read regardless of direction
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pc_low_flag_r <= 1'b0;
        end else if (pc_low_change) begin
            pc_low_flag_r <= 1'b1;
        end else if (i_flag_clear[SRC_PC_LOW] || (i_vector_ack && valid_r && source_r == 4'(SRC_PC_LOW))) begin
            pc_low_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pc_high_flag_r <= 1'b0;
        end else if (pc_high_change) begin
            pc_high_flag_r <= 1'b1;
        end else if (i_flag_clear[SRC_PC_HIGH] || (i_vector_ack && valid_r && source_r == 4'(SRC_PC_HIGH))) begin
            pc_high_flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Wake-up
    // ------------------------------------------------------------------
    // RULE12 RULE16 asynchronous paths straight from pins
    // RULE18 wake does not create a flag by itself
    assign o_wake_request = i_sleeping && (
        (i_pc_low_enable && pc_low_wake) ||
        (i_pc_high_enable && pc_high_wake) ||
        (i_ext_req_enable && sense == SENSE_LOW && !i_ext_request_pin));

    // ------------------------------------------------------------------
    // Priority and vector
    // ------------------------------------------------------------------
    // RULE18 level seen asleep only wakes; it must persist past wake-up
    assign pending = {i_other_requests, pc_high_flag_r, pc_low_flag_r, ext_flag_r | (level_low && !i_sleeping)};
    // RULE23 pin enables gated by global enable
    assign enabled = {13'h1FFF, i_pc_high_enable, i_pc_low_enable, i_ext_req_enable};
    // RULE7 only enabled sources may win
    assign active = i_global_enable ? (pending & enabled) : '0;

    // RULE24 lowest index wins
    always_comb begin
        win_idx = 4'h0;
        win_any = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (active[i]) begin
                win_idx = 4'(i);
                win_any = 1'b1;
            end
        end
    end

    // RULE2 RULE3 RULE4 RULE5 RULE6 one word per source from 0x0001
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            valid_r <= 1'b0;
            vector_r <= VEC_RESET;
            source_r <= 4'h0;
        end else if (!valid_r || i_vector_ack) begin
            valid_r <= win_any && !(valid_r && i_vector_ack);
            vector_r <= VEC_EXT_REQ + VEC_W'(win_idx);
            source_r <= win_idx;
        end
    end

    // RULE1 every reset source requests vector zero
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            reset_req_r <= 1'b1;
        end else if (i_reset_event) begin
            reset_req_r <= 1'b1;
        end else if (i_vector_ack && !valid_r) begin
            reset_req_r <= 1'b0;
        end
    end

    assign o_ext_request_flag = ext_flag_r;
    assign o_pc_low_flag = pc_low_flag_r;
    assign o_pc_high_flag = pc_high_flag_r;
    assign o_irq_valid = valid_r;
    assign o_vector = reset_req_r ? VEC_RESET : vector_r;
    assign o_irq_source = source_r;
    assign o_reset_vector_req = reset_req_r;

endmodule : ext_irq_and_vector_unit

/* File: hdl/ext_irq_pkg.sv */
// Constants for the external interrupt and vector unit
package ext_irq_pkg;

    // ------------------------------------------------------------------
    // Vector addresses
    // ------------------------------------------------------------------
    localparam int VEC_W = 16;
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_EXT_REQ = 16'h0001;
    localparam logic [15:0] VEC_PC_LOW = 16'h0002;
    localparam logic [15:0] VEC_PC_HIGH = 16'h0003;
    localparam logic [15:0] VEC_WDOG = 16'h0004;
    localparam logic [15:0] VEC_T16_CAPT = 16'h0005;
    localparam logic [15:0] VEC_T16_OVF = 16'h0008;
    localparam logic [15:0] VEC_T8_COMPA = 16'h0009;
    localparam logic [15:0] VEC_T8_OVF = 16'h000B;
    localparam logic [15:0] VEC_ANALOG_COMPARATOR_EVENT = 16'h000C;
    localparam logic [15:0] VEC_LAST = 16'h0010;

    // ------------------------------------------------------------------
    // Sources and fields
    // ------------------------------------------------------------------
    localparam int NUM_SRC = 16;
    localparam int SRC_EXT = 0;
    localparam int SRC_PC_LOW = 1;
    localparam int SRC_PC_HIGH = 2;
    localparam int NUM_PC = 12;
    localparam int PC_LOW_W = 8;
    localparam int PC_HIGH_W = 4;
    localparam int CTRL_ADDR = 8'h35;
    localparam int SENSE_LO_BIT = 0;
    localparam int SENSE_HI_BIT = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;

    typedef enum logic [1:0] {
        SENSE_LOW = 2'b00,
        SENSE_ANY = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } sense_e;

endpackage : ext_irq_pkg

/* File: hdl/pin_change_group.sv */
// Masked pin-change detector for one group of pins
`timescale 1ns/100ps
module pin_change_group #(
    parameter int WIDTH = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_pins,
    input wire logic [WIDTH-1:0] i_mask,
    output logic o_wake,
    output logic o_change
);
    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] prev_r;
    logic [WIDTH-1:0] armed_r;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= i_pins;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Detection armed on the first clock after reset, before sync_r has sampled the pins
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            armed_r <= '0;
        end else begin
            armed_r <= '1;
        end
    end

    // Clockless wake: raw pin differs from last sampled level
    assign o_wake = |((i_pins ^ sync_r) & i_mask & armed_r);
    assign o_change = |((sync_r ^ prev_r) & i_mask & armed_r);

endmodule : pin_change_group

/* File: tb/core_model.sv */
// Processor core stand-in that takes presented vectors
`timescale 1ns/100ps
module core_model (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_irq_valid,
    input wire logic i_reset_vector_req,
    input wire logic [15:0] i_vector,
    input wire logic i_go,
    output logic o_vector_ack,
    output logic [7:0] o_taken_cnt,
    output logic [15:0] o_taken_vec
);
    // ----------------------------------------
    // Vector fetch
    // ----------------------------------------
    // one ack per vector
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_vector_ack <= 1'b0;
            o_taken_cnt <= 8'h00;
            o_taken_vec <= 16'hFFFF;
        end else if (o_vector_ack) begin
            o_vector_ack <= 1'b0;
            o_taken_cnt <= o_taken_cnt + 8'h01;
            o_taken_vec <= i_vector;
        end else begin
            // Stalled while i_go low, so several requests can pile up
            o_vector_ack <= i_go && (i_irq_valid || i_reset_vector_req);
        end
    end
endmodule : core_model

/* File: tb/ext_irq_checker.sv */
// Port checker for the external interrupt and vector unit
`timescale 1ns/100ps
module ext_irq_checker
    import ext_irq_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [NUM_PC-1:0] i_pin_change_inputs,
    input wire logic [7:0] i_core_control_reg,
    input wire logic i_ext_req_enable,
    input wire logic [7:0] i_pin_change_mask_low,
    input wire logic i_global_enable,
    input wire logic i_vector_ack,
    input wire logic o_ext_request_flag,
    input wire logic o_pc_low_flag,
    input wire logic o_irq_valid,
    input wire logic [VEC_W-1:0] o_vector,
    input wire logic [3:0] o_irq_source,
    input wire logic o_reset_vector_req
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // ----------------------------------------
    // Steps and properties
    // ----------------------------------------
    sequence low_toggle_s;
        |((i_pin_change_inputs ^ $past(i_pin_change_inputs)) & {4'h0, i_pin_change_mask_low});
    endsequence
    sequence taken_s;
        o_irq_valid && i_vector_ack;
    endsequence
    reset_vec_a: assert property (o_reset_vector_req |-> o_vector == 16'h0000)
        else $error("reset vector not zero");
    vec_map_a: assert property (o_irq_valid && !o_reset_vector_req |-> o_vector == 16'h0001 + {12'h000, o_irq_source})
        else $error("vector does not match source");
    global_gate_a: assert property ($rose(o_irq_valid) |-> $past(i_global_enable))
        else $error("vector presented with global enable off");
    level_flag_a: assert property ((i_core_control_reg[1:0] == 2'b00) [*2] |-> !o_ext_request_flag)
        else $error("request flag set in level mode");
    low_group_a: assert property (low_toggle_s |-> ##[1:5] o_pc_low_flag)
        else $error("low group flag missed a toggle");
    stand_a: assert property (o_irq_valid && !i_vector_ack |=> o_irq_valid && $stable(o_vector))
        else $error("presented vector did not stand");
    ack_drop_a: assert property (taken_s |=> !o_irq_valid)
        else $error("valid stayed up after ack");
    ack_clear_a: assert property (taken_s ##0 (o_irq_source == 4'h0) |=> !o_ext_request_flag)
        else $error("ack left request flag set");
    lowest_first_a: assert property ($rose(o_irq_valid) && $past(o_ext_request_flag) && $past(i_ext_req_enable)
        |-> o_irq_source == 4'h0)
        else $error("lower vector not served first");
endmodule : ext_irq_checker

bind ext_irq_and_vector_unit ext_irq_checker ext_irq_checker_i (.*);

/* File: tb/tb_top.sv */
// Self-checking bench for the external interrupt and vector unit
`timescale 1ns/100ps
module tb_top;
    import ext_irq_pkg::*;
    logic i_sys_clk = 1'b0, i_rst = 1'b1, i_io_clk_run = 1'b1, i_ext_request_pin = 1'b1, i_vector_ack;
    logic i_ext_req_enable = 1'b1, i_pc_low_enable = 1'b1, i_pc_high_enable = 1'b1, i_global_enable = 1'b1;
    logic i_reset_event = 1'b0, i_sleeping = 1'b0, i_go = 1'b1;
    logic [NUM_PC-1:0] i_pin_change_inputs = 12'h000;
    logic [7:0] i_core_control_reg = 8'h00, i_pin_change_mask_low = 8'h10, i_pin_change_mask_high = 8'h01;
    logic [2:0] i_flag_clear = 3'h0;
    logic [12:0] i_other_requests = 13'h0000;
    logic o_ext_request_flag, o_pc_low_flag, o_pc_high_flag, o_irq_valid, o_wake_request, o_reset_vector_req;
    logic [VEC_W-1:0] o_vector;
    logic [3:0] o_irq_source;
    logic [7:0] taken_cnt, n;
    logic [15:0] taken_vec;
    int err_count = 0, cmp_count = 0, cycles = 0;

    always #2.5 i_sys_clk = ~i_sys_clk;
    ext_irq_and_vector_unit ext_irq_and_vector_unit_i (.*);
    core_model core_model_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_irq_valid(o_irq_valid),
        .i_reset_vector_req(o_reset_vector_req), .i_vector(o_vector), .i_go(i_go),
        .o_vector_ack(i_vector_ack), .o_taken_cnt(taken_cnt), .o_taken_vec(taken_vec));

    task automatic cyc(input int k);
        repeat (k) @(negedge i_sys_clk);
    endtask : cyc
    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, got);
        end
    endtask : chk
    // Waits for the core to take one vector, bounded
    task automatic take(input logic [15:0] exp);
        int k;
        n = taken_cnt;
        for (k = 0; k < 40 && taken_cnt == n; k++) cyc(1);
        chk(exp, (k < 40) ? taken_vec : 16'hDEAD);
    endtask : take
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    always @(posedge i_sys_clk) if (++cycles == 4000) begin
        err_count++;
        wrap_up();
    end

    initial begin
        cyc(2);
        chk(16'h0001, 16'(o_reset_vector_req));
        cyc(1);
        i_rst = 1'b0;
        take(16'h0000);
        $display("test done: reset");
        for (int i = 0; i < 13; i++) begin
            i_other_requests = 13'h0001 << i;
            take(16'h0004 + 16'(i));
            i_other_requests = 13'h0000;
            cyc(2);
        end
        $display("test done: vector table");
        i_go = 1'b0;
        i_core_control_reg = 8'h02;
        cyc(2);
        i_ext_request_pin = 1'b0;
        i_pin_change_inputs[8] = 1'b1;
        cyc(6);
        i_other_requests = 13'h0001;
        cyc(2);
        i_go = 1'b1;
        take(16'h0001);
        take(16'h0003);
        take(16'h0004);
        i_other_requests = 13'h0000;
        i_ext_request_pin = 1'b1;
        i_pin_change_inputs[0] = 1'b1;
        cyc(8);
        chk(16'h0000, 16'(o_pc_low_flag));
        i_pin_change_inputs[4] = 1'b1;
        take(16'h0002);
        i_pc_low_enable = 1'b0;
        i_pin_change_inputs[4] = 1'b0;
        cyc(8);
        chk(16'h0000, 16'(o_irq_valid));
        i_flag_clear = 3'h2;
        cyc(1);
        i_flag_clear = 3'h0;
        cyc(1);
        chk(16'h0000, 16'(o_pc_low_flag));
        i_pc_low_enable = 1'b1;
        $display("test done: priority and masks");
        for (int s = 1; s < 4; s++) begin
            i_core_control_reg = 8'(s);
            n = taken_cnt;
            cyc(4);
            i_ext_request_pin = 1'b0;
            cyc(8);
            i_ext_request_pin = 1'b1;
            cyc(12);
            chk((s == 1) ? 16'h0002 : 16'h0001, 16'(taken_cnt - n));
        end
        i_core_control_reg = 8'h00;
        n = taken_cnt;
        cyc(2);
        i_ext_request_pin = 1'b0;
        cyc(30);
        chk(16'h0000, 16'(o_ext_request_flag));
        i_ext_request_pin = 1'b1;
        cyc(6);
        chk(16'h0001, 16'(taken_cnt - n > 8'h01));
        $display("test done: sense modes");
        i_io_clk_run = 1'b0;
        i_core_control_reg = 8'h02;
        n = taken_cnt;
        cyc(2);
        i_ext_request_pin = 1'b0;
        cyc(8);
        chk(16'h0000, 16'(taken_cnt - n));
        i_ext_request_pin = 1'b1;
        i_io_clk_run = 1'b1;
        i_global_enable = 1'b0;
        cyc(4);
        i_ext_request_pin = 1'b0;
        cyc(8);
        chk(16'h0001, 16'(o_ext_request_flag));
        i_global_enable = 1'b1;
        take(16'h0001);
        i_ext_request_pin = 1'b1;
        $display("test done: io clock and global");
        i_sleeping = 1'b1;
        i_go = 1'b0;
        i_core_control_reg = 8'h00;
        cyc(2);
        i_ext_request_pin = 1'b0;
        #1 chk(16'h0001, 16'(o_wake_request));
        i_ext_request_pin = 1'b1;
        cyc(6);
        i_pin_change_inputs[4] = 1'b1;
        #1 chk(16'h0001, 16'(o_wake_request));
        cyc(6);
        i_sleeping = 1'b0;
        i_go = 1'b1;
        take(16'h0002);
        i_reset_event = 1'b1;
        cyc(1);
        i_reset_event = 1'b0;
        take(16'h0000);
        $display("test done: wake and reset event");
        wrap_up();
    end
endmodule : tb_top
